// ---- pdc_pkg.sv ----
/*
  Constants, types and decode helpers for the paged DRAM controller.
  Assumes a single 125 MHz clock domain shared by every design file.
*/
// Behaviour
// - On a page hit the row strobe stays low and only a column strobe is issued.
// - An active-low refresh strobe is produced with a refresh row that walks 512 rows.
// - The refresh interval is a software-writable count of clocks.
// - The refresh strobe is also driven on a separate buffered pin when the jumper selects it.
// - Between zero and three wait clocks are added to every memory or I/O cycle.
// - Command delay and wait counts come from a software-writable timing register.
// - On-board DRAM is two word-interleaved banks, each kept open in page mode.
// - On-board DRAM covers the lowest 4 MB of the address space, less the backplane hole from 0A0000 to 0EFFFF.
// - DRAM moves 16 data bits with one parity bit beside each byte lane.
// - Parity is generated on writes and checked on reads, flagging a mismatch in any byte lane enabled for the read.
// - With shadowing, EPROM data may be copied into RAM and that region then served from RAM.
// - After power-on the configuration is loaded from stored values or from defaults.
// - Backplane transfers other than EPROM cycles follow the card's width pin, splitting 16-bit words for 8-bit cards.
// - The processor address is 24 bits, spanning 16 MB.
package pdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_NS = 8;
  localparam int PRE_NS = 40;
  localparam int RCD_NS = 20;
  localparam int CAS_NS = 30;
  localparam int REF_NS = 80;
  localparam int REFRESH_PERIOD_NS = 15600;
  // Least times round up to whole clocks.
  localparam logic [3:0] PRE_CYC = 4'((PRE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RCD_CYC = 4'((RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CAS_CYC = 4'((CAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] REF_CYC = 4'((REF_NS + CLK_NS - 1) / CLK_NS);
  // A refresh period is a longest time, so it rounds down.
  localparam logic [11:0] DEF_REFRESH = 12'(REFRESH_PERIOD_NS / CLK_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map and fields.
  localparam logic [3:0] REG_REFRESH = 4'h0;
  localparam logic [3:0] REG_TIMING = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam int TIM_MEM_WS_LSB = 0;
  localparam int TIM_IO_WS_LSB = 2;
  localparam int TIM_DLY_LSB = 4;
  localparam int TIM_SHADOW_COPY = 6;
  localparam int TIM_SHADOW_EN = 7;
  localparam int STAT_PERR = 0;
  localparam int STAT_HIT = 1;
  localparam int STAT_ROW_LSB = 2;
  localparam logic [7:0] DEF_TIMING = 8'h1D;

  ////////////////////////////////////////////////////////////////////////////////
  // Address map.
  localparam logic [23:0] DRAM_TOP = 24'h400000;
  localparam logic [23:0] HOLE_LO = 24'h0A0000;
  localparam logic [23:0] SHADOW_LO = 24'h0F0000;
  localparam logic [23:0] SHADOW_HI = 24'h100000;
  localparam int BANK_BIT = 1;
  localparam int COL_LSB = 2;
  localparam int ROW_LSB = 12;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PRE = 7'h02,
    ST_RAS = 7'h04,
    ST_CAS = 7'h08,
    ST_BUS = 7'h10,
    ST_GAP = 7'h20,
    ST_REF = 7'h40
  } pdc_state_e;

  typedef enum logic [1:0] {
    TGT_DRAM = 2'h0,
    TGT_BUS = 2'h1,
    TGT_ROM = 2'h2,
    TGT_IO = 2'h3
  } pdc_tgt_e;

  // Picks the target of a cycle; the shadow window overrides the on-board DRAM range.
  function automatic pdc_tgt_e pdc_decode(input logic [23:0] a, input logic io,
                                          input logic wr, input logic [7:0] tim);
    if (io) begin
      return TGT_IO;
    end else if (a >= SHADOW_LO && a < SHADOW_HI) begin
      if (tim[TIM_SHADOW_EN] || (tim[TIM_SHADOW_COPY] && wr)) begin
        return TGT_DRAM;
      end
      return TGT_ROM;
    end else if (a >= HOLE_LO && a < SHADOW_LO) begin
      return TGT_BUS;
    end else if (a < DRAM_TOP) begin
      return TGT_DRAM;
    end
    return TGT_BUS;
  endfunction

endpackage

// ---- pdc_sync.sv ----
/*
  Three-flop input synchroniser with agreement filter.
  Assumes inputs are asynchronous pins; output is a clean level on clock.
*/
module pdc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // The first stage feeds only the second; a bit changes once stages two and three agree.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s2 & s3) | (q & (s2 | s3));
    end
  end

endmodule

// ---- pdc_parity.sv ----
/*
  Odd parity for each byte lane of a 16-bit word.
  Assumes a purely combinational use; no state.
*/
module pdc_parity (
  input wire logic [15:0] data,
  output logic [1:0] par
);

  // One parity bit per byte, set so that each lane carries an odd count of ones.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      par[i] = ~^data[8*i +: 8];
    end
  end

endmodule

// ---- pdc_top.sv ----
/*
  Paged, two-bank interleaved DRAM controller with refresh, parity,
  wait states, EPROM shadowing and backplane width sizing.
  Assumes requests, register strobes, DRAM data and stored configuration
  are on the clock; width and jumper pins are asynchronous.
*/
// Chosen here: the register offsets and the address-and-strobe port.
module pdc_top
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_io,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [1:0] req_be,
  output logic req_ready,
  output logic rsp_done,
  output logic [15:0] rsp_rdata,
  output logic rsp_perr,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic nv_valid,
  input wire logic [11:0] nv_refresh,
  input wire logic [7:0] nv_timing,
  output logic [1:0] dram_ras_n,
  output logic [1:0] dram_cas_n,
  output logic dram_we_n,
  output logic [9:0] dram_a,
  output logic [17:0] dram_dq_out,
  output logic dram_dq_oe_n,
  input wire logic [17:0] dram_dq_in,
  output logic refresh_n,
  output logic refresh_bp_n,
  input wire logic refresh_jumper,
  output logic [23:0] bp_addr,
  output logic [15:0] bp_dout,
  output logic bp_oe_n,
  input wire logic [15:0] bp_din,
  output logic bp_cmd_n,
  output logic bp_write,
  output logic bp_io,
  output logic rom_sel,
  input wire logic bp_mem16_n,
  input wire logic bp_io16_n
);

  typedef struct packed {
    pdc_state_e st;
    logic loaded;
    logic [11:0] ref_ivl;
    logic [7:0] timing;
    logic perr;
    logic hit;
    logic [11:0] ref_cnt;
    logic ref_pend;
    logic [8:0] ref_row;
    logic [3:0] cnt;
    logic [1:0] open;
    logic [1:0][9:0] open_row;
    logic wr;
    logic io;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    pdc_tgt_e tgt;
    logic half;
    logic ready;
    logic done;
    logic [15:0] rdata;
    logic rsp_perr;
    logic [1:0] ras_n;
    logic [1:0] cas_n;
    logic we_n;
    logic [9:0] dram_a;
    logic [17:0] dq_out;
    logic dq_oe_n;
    logic ref_n;
    logic ref_bp_n;
    logic [23:0] bp_addr;
    logic [15:0] bp_dout;
    logic bp_oe_n;
    logic bp_cmd_n;
    logic bp_wr;
    logic bp_io;
    logic rom_sel;
    logic [15:0] reg_rdata;
  } pdc_regs_s;

  pdc_regs_s s;
  pdc_regs_s next_s;

  logic [2:0] pins;
  logic mem16_n;
  logic io16_n;
  logic jumper;
  logic [15:0] wsrc;
  logic [1:0] wpar;
  logic [1:0] rpar;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins from the backplane and jumper field are asynchronous.
  pdc_sync #(.W(3)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({refresh_jumper, bp_io16_n, bp_mem16_n}),
    .q(pins)
  );
  assign mem16_n = pins[0];
  assign io16_n = pins[1];
  assign jumper = pins[2];

  // Page hits start the column straight from idle, so parity must see the port data then.
  assign wsrc = (s.st == ST_IDLE) ? req_wdata : s.wdata;

  pdc_parity u_wpar (
    .data(wsrc),
    .par(wpar)
  );

  pdc_parity u_rpar (
    .data(dram_dq_in[15:0]),
    .par(rpar)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole controller.
  always_comb begin
    logic [23:0] a;
    logic wr;
    logic io;
    logic [1:0] be;
    logic bank;
    logic [9:0] row;
    logic [1:0] ws;
    logic narrow;
    logic start_ras;
    logic start_cas;
    logic start_bus;
    logic finish;
    logic expire;
    pdc_tgt_e tgt;
    a = (s.st == ST_IDLE) ? req_addr : s.addr;
    wr = (s.st == ST_IDLE) ? req_write : s.wr;
    io = (s.st == ST_IDLE) ? req_io : s.io;
    be = (s.st == ST_IDLE) ? req_be : s.be;
    bank = a[BANK_BIT];
    row = a[ROW_LSB +: 10];
    tgt = pdc_decode(a, io, wr, s.timing);
    ws = io ? s.timing[TIM_IO_WS_LSB +: 2] : s.timing[TIM_MEM_WS_LSB +: 2];
    narrow = io ? io16_n : mem16_n;
    start_ras = 1'b0;
    start_cas = 1'b0;
    start_bus = 1'b0;
    finish = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.reg_rdata = 16'h0000;

    // Stored configuration is taken once, on the first edge after reset.
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.ref_ivl = nv_valid ? nv_refresh : DEF_REFRESH;
      next_s.timing = nv_valid ? nv_timing : DEF_TIMING;
    end

    // Refresh timer; an interval of zero stops refresh requests.
    expire = s.loaded && (s.ref_ivl != 12'h000) && (s.ref_cnt >= s.ref_ivl - 12'h001);
    next_s.ref_cnt = expire ? 12'h000 : s.ref_cnt + 12'h001;
    next_s.ref_pend = s.ref_pend | expire;

    unique case (s.st)
      ST_IDLE: begin
        if (s.ready && req_valid) begin
          next_s.ready = 1'b0;
          next_s.wr = req_write;
          next_s.io = req_io;
          next_s.addr = req_addr;
          next_s.wdata = req_wdata;
          next_s.be = req_be;
          next_s.tgt = tgt;
          next_s.half = 1'b0;
          next_s.rdata = 16'h0000;
          if (tgt == TGT_DRAM) begin
            // Each bank keeps its own open row, so alternate words hit both pages.
            next_s.hit = s.open[bank] && (s.open_row[bank] == row);
            if (s.open[bank] && (s.open_row[bank] == row)) begin
              start_cas = 1'b1;
            end else if (s.open[bank]) begin
              next_s.ras_n[bank] = 1'b1;
              next_s.open[bank] = 1'b0;
              next_s.cnt = PRE_CYC - 4'h1;
              next_s.st = ST_PRE;
            end else begin
              start_ras = 1'b1;
            end
          end else begin
            start_bus = 1'b1;
          end
        end else if (s.ref_pend) begin
          // Refresh closes both pages, so it starts with a full precharge.
          next_s.ready = 1'b0;
          next_s.ras_n = 2'b11;
          next_s.open = 2'b00;
          next_s.cnt = PRE_CYC + REF_CYC - 4'h1;
          next_s.st = ST_REF;
        end else begin
          next_s.ready = s.loaded;
        end
      end
      ST_PRE: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          start_ras = 1'b1;
        end
      end
      ST_RAS: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          start_cas = 1'b1;
        end
      end
      ST_CAS: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          // Only the column strobe falls back; the row stays open for the next hit.
          next_s.cas_n = 2'b11;
          next_s.we_n = 1'b1;
          next_s.dq_oe_n = 1'b1;
          if (!s.wr) begin
            next_s.rdata = dram_dq_in[15:0];
            next_s.rsp_perr = |((rpar ^ dram_dq_in[17:16]) & s.be);
          end else begin
            next_s.rsp_perr = 1'b0;
          end
          finish = 1'b1;
        end
      end
      ST_BUS: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h0) begin
          next_s.bp_cmd_n = 1'b1;
          next_s.bp_oe_n = 1'b1;
          next_s.rsp_perr = 1'b0;
          // The card's width is sampled as the command ends.
          if (!narrow || s.tgt == TGT_ROM) begin
            next_s.rdata = bp_din;
            finish = 1'b1;
          end else if (!s.half && (s.be == 2'b11)) begin
            next_s.rdata[7:0] = bp_din[7:0];
            next_s.half = 1'b1;
            next_s.st = ST_GAP;
          end else if (s.half || (s.be == 2'b10)) begin
            next_s.rdata[15:8] = bp_din[7:0];
            finish = 1'b1;
          end else begin
            next_s.rdata[7:0] = bp_din[7:0];
            finish = 1'b1;
          end
        end
      end
      ST_GAP: begin
        // One idle clock between the two byte commands of a split word.
        start_bus = 1'b1;
      end
      ST_REF: begin
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt <= REF_CYC) begin
          next_s.ras_n = 2'b00;
          next_s.ref_n = 1'b0;
          next_s.dram_a = {1'b0, s.ref_row};
        end
        if (s.cnt == 4'h0) begin
          next_s.ras_n = 2'b11;
          next_s.ref_n = 1'b1;
          next_s.ref_row = s.ref_row + 9'h001;
          next_s.ref_pend = expire; // Pending set wins over this completion.
          next_s.ready = !expire;
          next_s.st = ST_IDLE;
        end
      end
    endcase

    // Open the row of the addressed bank.
    if (start_ras) begin
      next_s.dram_a = row;
      next_s.ras_n[bank] = 1'b0;
      next_s.open[bank] = 1'b1;
      next_s.open_row[bank] = row;
      next_s.cnt = RCD_CYC - 4'h1;
      next_s.st = ST_RAS;
    end

    // Column access with stored parity and configured wait clocks.
    if (start_cas) begin
      next_s.dram_a = a[COL_LSB +: 10];
      next_s.cas_n = ~be;
      next_s.we_n = ~wr;
      next_s.dq_out = {wpar, wsrc};
      next_s.dq_oe_n = ~wr;
      next_s.cnt = CAS_CYC - 4'h1 + {2'b00, ws};
      next_s.st = ST_CAS;
    end

    // Backplane, EPROM or I/O command; the high byte is copied to the low lane for the second half of a split word or a high-byte-only cycle.
    if (start_bus) begin
      next_s.bp_addr = {a[23:1], a[0] | next_s.half | (be == 2'b10)};
      next_s.bp_dout = {wsrc[15:8], (next_s.half || be == 2'b10) ? wsrc[15:8] : wsrc[7:0]};
      next_s.bp_oe_n = ~wr;
      next_s.bp_wr = wr;
      next_s.bp_io = (tgt == TGT_IO);
      next_s.rom_sel = (tgt == TGT_ROM);
      next_s.bp_cmd_n = 1'b0;
      next_s.cnt = {2'b00, s.timing[TIM_DLY_LSB +: 2]} + {2'b00, ws};
      next_s.st = ST_BUS;
    end

    if (finish) begin
      next_s.done = 1'b1;
      next_s.ready = !next_s.ref_pend;
      next_s.st = ST_IDLE;
    end

    // Register writes; the configuration steers refresh, waits and shadowing.
    if (reg_wr) begin
      unique case (reg_addr)
        REG_REFRESH: next_s.ref_ivl = reg_wdata[11:0];
        REG_TIMING: next_s.timing = reg_wdata[7:0];
        REG_STATUS: next_s.perr = s.perr & ~reg_wdata[STAT_PERR];
        default: next_s.perr = next_s.perr;
      endcase
    end
    // A parity fault in the same cycle as its clear is kept.
    if (finish && next_s.rsp_perr) begin
      next_s.perr = 1'b1;
    end

    // Read data stand only in the cycle after the read strobe.
    if (reg_rd) begin
      unique case (reg_addr)
        REG_REFRESH: next_s.reg_rdata = {4'h0, s.ref_ivl};
        REG_TIMING: next_s.reg_rdata = {8'h00, s.timing};
        REG_STATUS: next_s.reg_rdata = {5'h00, s.ref_row, s.hit, s.perr};
        default: next_s.reg_rdata = 16'h0000;
      endcase
    end

    next_s.ref_bp_n = next_s.ref_n | ~jumper;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; every strobe starts inactive.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ras_n <= 2'b11;
      s.cas_n <= 2'b11;
      s.we_n <= 1'b1;
      s.dq_oe_n <= 1'b1;
      s.ref_n <= 1'b1;
      s.ref_bp_n <= 1'b1;
      s.bp_oe_n <= 1'b1;
      s.bp_cmd_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign req_ready = s.ready;
  assign rsp_done = s.done;
  assign rsp_rdata = s.rdata;
  assign rsp_perr = s.rsp_perr;
  assign reg_rdata = s.reg_rdata;
  assign dram_ras_n = s.ras_n;
  assign dram_cas_n = s.cas_n;
  assign dram_we_n = s.we_n;
  assign dram_a = s.dram_a;
  assign dram_dq_out = s.dq_out;
  assign dram_dq_oe_n = s.dq_oe_n;
  assign refresh_n = s.ref_n;
  assign refresh_bp_n = s.ref_bp_n;
  assign bp_addr = s.bp_addr;
  assign bp_dout = s.bp_dout;
  assign bp_oe_n = s.bp_oe_n;
  assign bp_cmd_n = s.bp_cmd_n;
  assign bp_write = s.bp_wr;
  assign bp_io = s.bp_io;
  assign rom_sel = s.rom_sel;

endmodule

// ---- pdc_props.sv ----
/*
  Port checker for the paged DRAM controller.
  Assumes one clock domain and the asynchronous active-low reset of pdc_top.
*/
module pdc_props
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0] dram_ras_n,
  input wire logic [1:0] dram_cas_n,
  input wire logic [17:0] dram_dq_out,
  input wire logic dram_dq_oe_n,
  input wire logic refresh_n,
  input wire logic refresh_bp_n,
  input wire logic bp_cmd_n,
  input wire logic [23:0] bp_addr,
  input wire logic rom_sel
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // A refresh holds its strobe for ten clocks; a precharge keeps the row high five.
  sequence s_ref_low;
    !refresh_n [*8] ##1 !refresh_n [*2];
  endsequence
  sequence s_precharge;
    dram_ras_n[0] [*5];
  endsequence

  property p_ref_rows;
    !refresh_n |-> dram_ras_n == 2'b00 && dram_cas_n == 2'b11;
  endproperty
  a_ref_rows: assert property (p_ref_rows) else $error("refresh without all rows strobed");
  property p_ref_len;
    $fell(refresh_n) |-> s_ref_low ##1 refresh_n;
  endproperty
  a_ref_len: assert property (p_ref_len) else $error("refresh strobe length wrong");
  // The backplane copy never shows a strobe of its own.
  property p_ref_copy;
    !refresh_bp_n |-> !refresh_n || $past(refresh_n) == 1'b0;
  endproperty
  a_ref_copy: assert property (p_ref_copy) else $error("backplane refresh unmatched");
  property p_cas_ras;
    dram_cas_n != 2'b11 |-> dram_ras_n != 2'b11;
  endproperty
  a_cas_ras: assert property (p_cas_ras) else $error("column strobe with no open row");
  property p_precharge;
    $rose(dram_ras_n[0]) && $past(refresh_n) |-> s_precharge;
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge too short");
  property p_wr_parity;
    !dram_dq_oe_n && dram_cas_n != 2'b11 |->
      dram_dq_out[17:16] == {~^dram_dq_out[15:8], ~^dram_dq_out[7:0]};
  endproperty
  a_wr_parity: assert property (p_wr_parity) else $error("write parity wrong");
  property p_cmd_len;
    $fell(bp_cmd_n) |-> ##[1:7] $rose(bp_cmd_n);
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("bus command too long");
  property p_rom_win;
    !bp_cmd_n && rom_sel |-> bp_addr >= SHADOW_LO && bp_addr < SHADOW_HI;
  endproperty
  a_rom_win: assert property (p_rom_win) else $error("eprom cycle outside window");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
endmodule

bind pdc_top pdc_props i_props (.*);

// ---- pdc_far_model.sv ----
/*
  Behavioural DRAM banks and backplane card facing pdc_top.
  Assumes strobes change just after the rising clock edge.
*/
module pdc_far_model (
  input wire logic clock,
  input wire logic [1:0] dram_ras_n,
  input wire logic [1:0] dram_cas_n,
  input wire logic dram_we_n,
  input wire logic [9:0] dram_a,
  input wire logic [17:0] dram_dq_out,
  output logic [17:0] dram_dq_in,
  input wire logic bad_par,
  input wire logic bp_cmd_n,
  input wire logic bp_write,
  input wire logic [23:0] bp_addr,
  output logic [15:0] bp_din
);
  logic [17:0] mem [int];
  logic [9:0] row [2];
  logic [1:0] ras_q = 2'b11;
  logic bank = 1'b0;
  logic [15:0] idle = 16'h5A5A;
  int key;

  initial dram_dq_in = 18'h15555;

  ////////////////////////////////////////////////////////////////////////////////
  // The bank whose row fell last owns the columns.
  always @(posedge clock) begin
    for (int b = 0; b < 2; b++) begin
      if (ras_q[b] && !dram_ras_n[b]) begin
        row[b] = dram_a;
        bank = b[0];
      end
    end
    ras_q = dram_ras_n;
    key = int'({bank, row[bank], dram_a});
    if (dram_cas_n != 2'b11 && !dram_we_n) begin
      if (!mem.exists(key)) mem[key] = 18'h0;
      if (!dram_cas_n[0]) {mem[key][16], mem[key][7:0]} = {dram_dq_out[16], dram_dq_out[7:0]};
      if (!dram_cas_n[1]) {mem[key][17], mem[key][15:8]} = {dram_dq_out[17], dram_dq_out[15:8]};
    end
    // Outside a read the data lines wander so stale values cannot pass.
    if (dram_cas_n != 2'b11 && dram_we_n) begin
      dram_dq_in <= (mem.exists(key) ? mem[key] : 18'h2AAAA) ^ {bad_par, 17'h0};
    end else begin
      dram_dq_in <= ~dram_dq_in;
    end
    idle <= ~idle;
  end

  // The card answers at once from its address.
  assign bp_din = (!bp_cmd_n && !bp_write) ? {~bp_addr[7:0], bp_addr[7:0]} : idle;
endmodule

// ---- testbench.sv ----
/*
  Self-checking bench for pdc_top with a DRAM and backplane model.
  Assumes the 8 ns clock and the register indices of pdc_pkg.
*/
module testbench
  import pdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, nrst = 0, req_valid = 0, req_write = 0, req_io = 0, reg_wr = 0, reg_rd = 0;
  logic nv_valid = 0, refresh_jumper = 1, bp_mem16_n = 0, bp_io16_n = 0, bad_par = 0;
  logic [23:0] req_addr = 24'h0, bp_addr;
  logic [15:0] req_wdata = 16'h0, reg_wdata = 16'h0, rsp_rdata, reg_rdata, bp_dout, bp_din;
  logic [1:0] req_be = 2'h3, dram_ras_n, dram_cas_n;
  logic [3:0] reg_addr = 4'h0;
  logic [11:0] nv_refresh = 12'h0;
  logic [7:0] nv_timing = 8'h0;
  logic req_ready, rsp_done, rsp_perr, dram_we_n, dram_dq_oe_n, refresh_n, refresh_bp_n;
  logic bp_oe_n, bp_cmd_n, bp_write, bp_io, rom_sel;
  logic [9:0] dram_a;
  logic [17:0] dram_dq_out, dram_dq_in;
  int n_fail = 0, tests_run = 0;

  pdc_top i_dut (.clock, .nrst, .req_valid, .req_write, .req_io, .req_addr, .req_wdata, .req_be,
    .req_ready, .rsp_done, .rsp_rdata, .rsp_perr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .nv_valid, .nv_refresh, .nv_timing, .dram_ras_n, .dram_cas_n, .dram_we_n,
    .dram_a, .dram_dq_out, .dram_dq_oe_n, .dram_dq_in, .refresh_n, .refresh_bp_n,
    .refresh_jumper, .bp_addr, .bp_dout, .bp_oe_n, .bp_din, .bp_cmd_n, .bp_write, .bp_io,
    .rom_sel, .bp_mem16_n, .bp_io16_n);
  pdc_far_model i_far (.clock, .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_a, .dram_dq_out,
    .dram_dq_in, .bad_par, .bp_cmd_n, .bp_write, .bp_addr, .bp_din);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // Latency counts edges after the take.
  task automatic req(input logic w, input logic io, input logic [23:0] a, input logic [15:0] d,
                     input logic [1:0] be, output logic [15:0] rd, output int cyc);
    int n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_io <= io;
    req_addr <= a;
    req_wdata <= d;
    req_be <= be;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    req_valid <= 1'b0;
    cyc = 0;
    do begin
      @(negedge clock);
      cyc++;
    end while (rsp_done !== 1'b1 && cyc < 300);
    if (n >= 3000 || cyc >= 300) begin
      n_fail++;
      end_sim();
    end
    rd = rsp_rdata;
  endtask
  task automatic wait_ref(output logic [9:0] row, output int gap);
    logic p = 1'b0;
    gap = 0;
    do begin
      p = refresh_n;
      @(negedge clock);
      gap++;
    end while (!(p === 1'b1 && refresh_n === 1'b0) && gap < 1000);
    if (gap >= 1000) begin
      n_fail++;
      end_sim();
    end
    row = dram_a;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    logic [15:0] d;
    rd_reg(REG_REFRESH, d);
    chk(d, 24'(DEF_REFRESH));
    rd_reg(REG_TIMING, d);
    chk(d, 24'(DEF_TIMING));
    rd_reg(4'hF, d);
    chk(d, 24'h0);
    wr_reg(REG_REFRESH, 16'h0000);
    rd_reg(REG_REFRESH, d);
    chk(d, 24'h0);
  endtask
  task automatic t_dram();
    logic [15:0] d;
    int c0, ch, cm, cc;
    req(1, 0, 24'h001000, 16'hA55A, 2'b11, d, c0);
    req(0, 0, 24'h001000, 16'h0, 2'b11, d, ch);
    chk(d, 24'hA55A);
    rd_reg(REG_STATUS, d);
    chk(d[STAT_HIT], 1'b1);
    req(0, 0, 24'h002000, 16'h0, 2'b11, d, cm);
    chk(24'(cm - ch), 24'(PRE_CYC + RCD_CYC));
    req(0, 0, 24'h003002, 16'h0, 2'b11, d, cc);
    chk(24'(cc - ch), 24'(RCD_CYC));
    req(1, 0, 24'h001000, 16'h1234, 2'b01, d, c0);
    req(0, 0, 24'h001000, 16'h0, 2'b11, d, c0);
    chk(d, 24'hA534);
  endtask
  task automatic t_wait();
    logic [15:0] d;
    int lat [4];
    for (int w = 0; w < 4; w++) begin
      wr_reg(REG_TIMING, 16'(8'h1C | w));
      req(0, 0, 24'h001000, 16'h0, 2'b11, d, lat[w]);
      chk(24'(lat[w] - lat[0]), 24'(w));
    end
  endtask
  task automatic t_bus();
    logic [15:0] d;
    int c0, c1;
    wr_reg(REG_TIMING, 16'h000D);
    req(0, 0, 24'h400000, 16'h0, 2'b11, d, c0);
    chk(d, 24'hFF00);
    req(0, 0, 24'hFFFFFE, 16'h0, 2'b11, d, c0);
    chk(d, 24'h01FE);
    req(0, 1, 24'h000300, 16'h0, 2'b11, d, c0);
    wr_reg(REG_TIMING, 16'h003D);
    req(0, 1, 24'h000300, 16'h0, 2'b11, d, c1);
    chk(d, 24'hFF00);
    chk(24'(c1 - c0), 24'h3);
    @(posedge clock);
    bp_mem16_n <= 1'b1;
    repeat (6) @(posedge clock);
    req(0, 0, 24'h400010, 16'h0, 2'b11, d, c0);
    chk(d, 24'h1110);
  endtask
  task automatic t_parity();
    logic [15:0] d;
    int c;
    @(posedge clock);
    bad_par <= 1'b1;
    req(0, 0, 24'h001000, 16'h0, 2'b11, d, c);
    chk(rsp_perr, 1'b1);
    @(posedge clock);
    bad_par <= 1'b0;
    rd_reg(REG_STATUS, d);
    chk(d[STAT_PERR], 1'b1);
    wr_reg(REG_STATUS, 16'h0001);
    rd_reg(REG_STATUS, d);
    chk(d[STAT_PERR], 1'b0);
    req(0, 0, 24'h001000, 16'h0, 2'b11, d, c);
    chk(rsp_perr, 1'b0);
  endtask
  task automatic t_shadow();
    logic [15:0] d;
    int c;
    wr_reg(REG_TIMING, 16'h001D);
    req(0, 0, 24'h0F0010, 16'h0, 2'b11, d, c);
    chk(d, 24'hEF10);
    wr_reg(REG_TIMING, 16'h005D);
    req(1, 0, 24'h0F0010, 16'hC0DE, 2'b11, d, c);
    req(0, 0, 24'h0F0010, 16'h0, 2'b11, d, c);
    chk(d, 24'hEF10);
    wr_reg(REG_TIMING, 16'h009D);
    req(0, 0, 24'h0F0010, 16'h0, 2'b11, d, c);
    chk(d, 24'hC0DE);
  endtask
  // A mid-run reset loads stored values; the refresh row walks a lap.
  task automatic t_refresh();
    logic [15:0] d;
    logic [9:0] r0, r;
    int g;
    @(posedge clock);
    nrst <= 1'b0;
    nv_valid <= 1'b1;
    nv_refresh <= 12'h018;
    nv_timing <= 8'h9D;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd_reg(REG_REFRESH, d);
    chk(d, 24'h018);
    rd_reg(REG_TIMING, d);
    chk(d, 24'h9D);
    wait_ref(r0, g);
    chk(refresh_bp_n, 1'b0);
    wait_ref(r, g);
    chk(24'(g), 24'h18);
    chk(r[8:0], 9'(r0[8:0] + 9'h1));
    @(posedge clock);
    refresh_jumper <= 1'b0;
    for (int k = 0; k < 512; k++) wait_ref(r, g);
    chk(r[8:0], 9'(r0[8:0] + 9'h1));
    chk(refresh_bp_n, 1'b1);
  endtask

  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_dram();
    t_wait();
    t_bus();
    t_parity();
    t_shadow();
    t_refresh();
    end_sim();
  end
endmodule
